// ==== rtl/host_port.sv ====
// host port registers, burst engine and read data fifo
//
// How it works
// R1: control bit D2 write starts soft reset
// R2: interrupt driven only while D1 is zero
// R3: two fixed read-only identification registers
// R4: second identification reads first one inverted
// R5: every register answers in both windows
// R6: host keeps lowest address line low
// R7: separate burst read and write configs
// R8: hold bit gives one or two clocks
// R9: length code selects 4 to 32 words
// R10: first word latched two plus delay clocks
// R11: two-clock hold keeps every word twice
// R12: trailing code sets clocks after word N
// R13: write trailing clocks count from word N
// R14: burst only while enable bit set
// R15: host bursts only under dma transfers
// R16: warm boot clears enables unless kept
// R17: exit register write leaves burst write
// R18: reserved bits zero, fields reset zero
// R19: soft reset held while bit stays one
`timescale 1ns/1ps

// synchronous fifo with registered input ready
module stream_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_q;
	logic [AW-1:0]    rp_q;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;
	logic             push;
	logic             pop;

	// handshakes and occupancy
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem[rp_q];
	assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

	// storage
	always_ff @(posedge clk) begin
		if (push)
			mem[wp_q] <= in_data;
	end

	// pointers, count and ready
	always_ff @(posedge clk) begin
		if (rst) begin
			wp_q     <= '0;
			rp_q     <= '0;
			cnt_q    <= '0;
			in_ready <= 1'b1;
		end else begin
			if (push)
				wp_q <= wp_q + 1'b1;
			if (pop)
				rp_q <= rp_q + 1'b1;
			cnt_q    <= cnt_d;
			in_ready <= (cnt_d != (AW+1)'(DEPTH));
		end
	end
endmodule : stream_fifo

// host port control and burst engine
module host_port import hp_pkg::*; #(
	parameter logic [15:0] PART_ID = PART_ID_DEF
) (
	input  wire logic        sys_clk,
	input  wire logic        soft_reset_bit,
	input  wire logic        burst_clk,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [16:0] addr,
	input  wire logic [15:0] d_in,
	output logic [15:0]      reg_d_out,
	output logic             reg_d_oe,
	output logic [15:0]      burst_d_out,
	output logic             burst_d_oe,
	input  wire logic        dev_event,
	output logic             irq_n,
	output logic             soft_reset,
	input  wire logic        warm_boot,
	input  wire logic        keep_burst,
	input  wire logic [15:0] rd_data,
	input  wire logic        rd_valid,
	output logic             rd_ready,
	output logic [15:0]      wr_data,
	output logic             wr_valid
);
	// address decode for both windows
	function automatic reg_sel_t decode(input logic [16:0] a);
		if (a == CTRL_BIG || a == CTRL_SMALL)
			decode = SEL_CTRL;
		else if (a == ID0_BIG || a == ID0_SMALL)
			decode = SEL_ID0;
		else if (a == ID1_BIG || a == ID1_SMALL)
			decode = SEL_ID1;
		else if (a == BWCFG_BIG || a == BWCFG_SMALL)
			decode = SEL_BW;
		else if (a == BRCFG_BIG || a == BRCFG_SMALL)
			decode = SEL_BR;
		else if (a == EXIT_BIG || a == EXIT_SMALL)
			decode = SEL_EXIT;
		else
			decode = SEL_NONE;
	endfunction : decode

	logic [35:0] pin_s1;
	logic [35:0] pin_s2;
	logic [35:0] pin_s3;
	logic [2:0]  stb_q;
	logic        act_wr;
	logic        act_rd;
	logic        wr_act_q;
	logic [16:0] wa_q;
	logic [15:0] wd_q;
	logic        commit;
	reg_sel_t    wsel;
	reg_sel_t    rsel;
	reg_sel_t    rsel_q;
	logic [7:0]  ctrl_q;
	logic [15:0] bw_cfg_q;
	logic [15:0] br_cfg_q;
	logic        wr_mode_q;
	logic        int_rst;
	logic [15:0] f_data;
	logic        f_valid;
	logic        f_ready;
	logic [15:0] stage_q [4];
	logic [3:0]  full_q;
	logic [3:0]  ack_tgl_q;
	logic [1:0]  fill_ptr_q;
	logic [3:0]  rq_s1;
	logic [3:0]  rq_s2;
	logic [3:0]  rq_s3;
	logic        bt_s1;
	logic        bt_s2;
	logic        bt_s3;

	// three-stage pin synchronisers
	always_ff @(posedge sys_clk) begin
		pin_s1 <= {ce_n, oe_n, we_n, addr, d_in};
		pin_s2 <= pin_s1;
		pin_s3 <= pin_s2;
	end

	// strobes accepted once second and third stages agree
	always_ff @(posedge sys_clk) begin
		if (soft_reset_bit)
			stb_q <= 3'h7;
		else if (pin_s2[35:33] == pin_s3[35:33])
			stb_q <= pin_s3[35:33];
	end

	// write and read activity, lowest address line must be low
	assign act_wr = !stb_q[2] && !stb_q[0];
	assign act_rd = !stb_q[2] && !stb_q[1];
	assign rsel   = decode(pin_s3[32:16]); // R6
	assign wsel   = decode(wa_q); // R5
	assign commit = wr_act_q && !act_wr;

	// capture address and data while the write strobe is low
	always_ff @(posedge sys_clk) begin
		if (soft_reset_bit) begin
			wr_act_q <= 1'b0;
			wa_q     <= '0;
			wd_q     <= '0;
		end else begin
			wr_act_q <= act_wr;
			// only samples that still show the strobes low carry data
			if (act_wr && !pin_s3[35] && !pin_s3[33]) begin
				wa_q <= pin_s3[32:16];
				wd_q <= pin_s3[15:0];
			end
		end
	end

	// device control, only hard reset clears it
	always_ff @(posedge sys_clk) begin
		if (soft_reset_bit)
			ctrl_q <= CTRL_RST;
		else if (commit && wsel == SEL_CTRL)
			ctrl_q <= wd_q[7:0] & CTRL_WMASK; // R18
	end

	// soft reset holds internal logic while the bit is one
	assign int_rst = soft_reset_bit || ctrl_q[CTRL_SOFT_BIT]; // R19

	always_ff @(posedge sys_clk) begin
		if (soft_reset_bit)
			soft_reset <= 1'b0;
		else
			soft_reset <= ctrl_q[CTRL_SOFT_BIT]; // R1
	end

	// interrupt line gated by the disable bit
	always_ff @(posedge sys_clk) begin
		if (soft_reset_bit)
			irq_n <= 1'b1;
		else
			irq_n <= !(dev_event && !ctrl_q[CTRL_IDIS_BIT]); // R2
	end

	// burst configurations, warm boot has last word
	always_ff @(posedge sys_clk) begin
		if (int_rst) begin
			bw_cfg_q <= CFG_RST; // R18
			br_cfg_q <= CFG_RST;
		end else begin
			if (commit && wsel == SEL_BW)
				bw_cfg_q <= wd_q & CFG_WMASK; // R7
			if (commit && wsel == SEL_BR)
				br_cfg_q <= wd_q & CFG_WMASK; // R7
			if (warm_boot && !keep_burst) begin
				bw_cfg_q[CFG_EN_BIT] <= 1'b0; // R16
				br_cfg_q[CFG_EN_BIT] <= 1'b0; // R16
			end
		end
	end

	// burst write mode: entered by enabling, left by exit write
	always_ff @(posedge sys_clk) begin
		if (int_rst)
			wr_mode_q <= 1'b0;
		else if (commit && wsel == SEL_EXIT)
			wr_mode_q <= 1'b0; // R17
		else if (commit && wsel == SEL_BW && wd_q[CFG_EN_BIT])
			wr_mode_q <= 1'b1;
	end

	// register read answer
	always_ff @(posedge sys_clk) begin
		if (soft_reset_bit) begin
			reg_d_oe  <= 1'b0;
			reg_d_out <= '0;
			rsel_q    <= SEL_NONE;
		end else begin
			rsel_q   <= rsel;
			reg_d_oe <= act_rd && rsel != SEL_NONE && rsel != SEL_EXIT;
			case (rsel)
				SEL_CTRL: reg_d_out <= {8'h00, ctrl_q};
				SEL_ID0:  reg_d_out <= PART_ID; // R3
				SEL_ID1:  reg_d_out <= ~PART_ID; // R4
				SEL_BW:   reg_d_out <= bw_cfg_q;
				SEL_BR:   reg_d_out <= br_cfg_q;
				default:  reg_d_out <= '0;
			endcase
		end
	end

	// read data buffer from the device core
	stream_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) rd_fifo (
		.clk      (sys_clk),
		.rst      (int_rst),
		.in_data  (rd_data),
		.in_valid (rd_valid),
		.in_ready (rd_ready),
		.out_data (f_data),
		.out_valid(f_valid),
		.out_ready(f_ready)
	);

	// toggle synchronisers from the burst domain
	logic [3:0]  req_tgl_q;
	logic        bw_tgl_q;
	logic [15:0] bw_word_q;
	always_ff @(posedge sys_clk) begin
		rq_s1 <= req_tgl_q;
		rq_s2 <= rq_s1;
		rq_s3 <= rq_s2;
		bt_s1 <= bw_tgl_q;
		bt_s2 <= bt_s1;
		bt_s3 <= bt_s2;
	end

	// ring of four staged words; four slots hide the round trip of
	// the toggle synchronisers so one word per burst clock keeps up
	assign f_ready = !full_q[fill_ptr_q];
	always_ff @(posedge sys_clk) begin
		if (int_rst) begin
			full_q     <= '0;
			ack_tgl_q  <= '0;
			fill_ptr_q <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (rq_s2[i] != rq_s3[i])
					full_q[i] <= 1'b0;
			end
			if (f_ready && f_valid) begin
				full_q[fill_ptr_q]    <= 1'b1;
				ack_tgl_q[fill_ptr_q] <= !ack_tgl_q[fill_ptr_q];
				fill_ptr_q            <= fill_ptr_q + 2'h1;
			end
		end
	end

	// slot storage, stable while its toggle crosses
	always_ff @(posedge sys_clk) begin
		if (f_ready && f_valid)
			stage_q[fill_ptr_q] <= f_data;
	end

	// hand burst write words to the core
	always_ff @(posedge sys_clk) begin
		if (int_rst) begin
			wr_valid <= 1'b0;
			wr_data  <= '0;
		end else begin
			wr_valid <= (bt_s2 != bt_s3);
			if (bt_s2 != bt_s3)
				wr_data <= bw_word_q;
		end
	end

	// burst clock domain
	logic        brst_s1;
	logic        brst_s2;
	logic [32:0] cfg_s1;
	logic [32:0] cfg_s2;
	logic [3:0]  ack_s1;
	logic [3:0]  ack_s2;
	logic [1:0]  take_ptr_q;
	bst_t        st_q;
	logic        dir_wr_q;
	logic [15:0] cfg_q;
	logic [2:0]  cnt_q;
	logic [4:0]  widx_q;
	logic        ph_q;
	logic [15:0] cfg_in;
	logic        start;
	logic        last;
	logic        step;
	logic        load;
	logic [2:0]  lat;
	logic [1:0]  wt;
	logic [2:0]  extra;

	// reset and quasi-static configuration into the burst domain
	always_ff @(posedge burst_clk) begin
		brst_s1 <= int_rst;
		brst_s2 <= brst_s1;
		cfg_s1  <= {wr_mode_q, bw_cfg_q, br_cfg_q};
		cfg_s2  <= cfg_s1;
		ack_s1  <= ack_tgl_q;
		ack_s2  <= ack_s1;
	end

	// start decode and field extraction
	assign cfg_in = !we_n ? cfg_s2[31:16] : cfg_s2[15:0];
	assign start  = !ce_n && (addr == DPORT_BIG || addr == DPORT_SMALL)
		&& (!we_n ? (cfg_s2[32] && cfg_s2[16+CFG_EN_BIT])
			: (!oe_n && cfg_s2[CFG_EN_BIT])); // R14
	assign lat   = cfg_q[CFG_LAT_LSB +: 3];
	assign wt    = cfg_q[CFG_WAIT_LSB +: 2];
	assign last  = widx_q == 5'((6'h04 << cfg_q[CFG_LEN_LSB +: 2]) - 6'h01);
	assign step  = !(cfg_q[CFG_HOLD_BIT] && !ph_q); // R8
	// write trailing counts from word N itself, read from the clock after
	assign extra = dir_wr_q ? {1'b0, wt} // R13
		: (wt == 2'h0 ? 3'h0 : {1'b0, wt - 2'h1}); // R12

	// burst sequencer
	always_ff @(posedge burst_clk) begin
		if (brst_s2) begin
			st_q     <= B_IDLE;
			dir_wr_q <= 1'b0;
			cfg_q    <= CFG_RST;
			cnt_q    <= '0;
			widx_q   <= '0;
			ph_q     <= 1'b0;
		end else if (ce_n && st_q != B_IDLE) begin
			st_q <= B_IDLE;
		end else begin
			case (st_q)
				B_IDLE: if (start) begin
					dir_wr_q <= !we_n;
					cfg_q    <= cfg_in;
					cnt_q    <= 3'h1;
					widx_q   <= '0;
					ph_q     <= 1'b0;
					st_q     <= (cfg_in[CFG_LAT_LSB +: 3] == 3'h0)
						? B_DATA : B_LAT; // R10
				end
				B_LAT: begin
					cnt_q <= cnt_q + 3'h1;
					if (cnt_q == lat)
						st_q <= B_DATA; // R10
				end
				B_DATA: if (!step) begin
					ph_q <= 1'b1; // R11
				end else begin
					ph_q <= 1'b0;
					if (last) begin
						cnt_q <= 3'h1;
						st_q  <= (extra == 3'h0) ? B_END : B_TRAIL; // R12
					end else begin
						widx_q <= widx_q + 5'h01; // R9
					end
				end
				B_TRAIL: begin
					cnt_q <= cnt_q + 3'h1;
					if (cnt_q == extra)
						st_q <= B_END;
				end
				default: ;
			endcase
		end
	end

	// read word load points: one clock before each latch edge
	assign load = !dir_wr_q && (
		(st_q == B_LAT && cnt_q == lat) ||
		(st_q == B_DATA && step && !last)) ||
		(st_q == B_IDLE && start && we_n
			&& cfg_in[CFG_LAT_LSB +: 3] == 3'h0);

	// read data driver, takes ring slots in order
	always_ff @(posedge burst_clk) begin
		if (brst_s2) begin
			burst_d_out <= '0;
			burst_d_oe  <= 1'b0;
			req_tgl_q   <= '0;
			take_ptr_q  <= '0;
		end else begin
			if (ce_n)
				burst_d_oe <= 1'b0;
			else if (load)
				burst_d_oe <= 1'b1;
			if (load && ack_s2[take_ptr_q] != req_tgl_q[take_ptr_q]) begin
				burst_d_out           <= stage_q[take_ptr_q];
				req_tgl_q[take_ptr_q] <= !req_tgl_q[take_ptr_q];
				take_ptr_q            <= take_ptr_q + 2'h1;
			end
		end
	end

	// write capture on the first clock of each word
	always_ff @(posedge burst_clk) begin
		if (brst_s2) begin
			bw_word_q <= '0;
			bw_tgl_q  <= 1'b0;
		end else if (st_q == B_DATA && dir_wr_q && !ph_q && !ce_n) begin
			bw_word_q <= d_in; // R8
			bw_tgl_q  <= !bw_tgl_q;
		end
	end

	sr_clear_a: assert property (@(posedge sys_clk) // R19
		disable iff (soft_reset_bit) ctrl_q[CTRL_SOFT_BIT] |=> bw_cfg_q == CFG_RST
		&& br_cfg_q == CFG_RST && !wr_mode_q && soft_reset)
		else $error("soft reset did not clear burst state");
	irq_gate_a: assert property (@(posedge sys_clk) // R2
		disable iff (soft_reset_bit) ctrl_q[CTRL_IDIS_BIT] |=> irq_n)
		else $error("interrupt asserted while disabled");
	id_pair_a: assert property (@(posedge sys_clk) // R4
		disable iff (soft_reset_bit) reg_d_oe && rsel_q == SEL_ID1
		|-> reg_d_out == ~PART_ID)
		else $error("inverse identification mismatch");
	warm_clr_a: assert property (@(posedge sys_clk) // R16
		disable iff (int_rst) warm_boot && !keep_burst
		|=> !bw_cfg_q[CFG_EN_BIT] && !br_cfg_q[CFG_EN_BIT])
		else $error("warm boot left burst enabled");
	exit_mode_a: assert property (@(posedge sys_clk) // R17
		disable iff (int_rst) commit && wsel == SEL_EXIT |=> !wr_mode_q)
		else $error("exit write left burst write mode");
	rsv_zero_a: assert property (@(posedge sys_clk) // R18
		disable iff (soft_reset_bit) (bw_cfg_q & ~CFG_WMASK) == '0
		&& (ctrl_q & ~CTRL_WMASK) == '0)
		else $error("reserved bits set");
	burst_en_a: assert property (@(posedge burst_clk) // R14
		disable iff (brst_s2) st_q == B_IDLE && !start |=> st_q == B_IDLE)
		else $error("burst started without enable");
	lat_bound_a: assert property (@(posedge burst_clk) // R10
		disable iff (brst_s2) st_q == B_LAT |-> cnt_q <= lat && cnt_q != 0)
		else $error("first_word_delay count out of range");
	hold_two_a: assert property (@(posedge burst_clk) // R11
		disable iff (brst_s2) st_q == B_DATA && !ce_n && !step && !dir_wr_q
		|=> $stable(burst_d_out))
		else $error("word not held for second clock");
	word_cnt_a: assert property (@(posedge burst_clk) // R9
		disable iff (brst_s2) st_q == B_DATA && last && step && !ce_n
		|=> st_q != B_DATA)
		else $error("burst ran past its length");
endmodule : host_port

// ==== rtl/hp_pkg.sv ====
// constants and types shared by the host port control block
package hp_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 16;
	// register addresses, large window and small window aliases
	localparam logic [16:0] CTRL_BIG    = 17'h0801C;
	localparam logic [16:0] CTRL_SMALL  = 17'h0081C;
	localparam logic [16:0] ID0_BIG     = 17'h09400;
	localparam logic [16:0] ID0_SMALL   = 17'h01400;
	localparam logic [16:0] BWCFG_BIG   = 17'h09402;
	localparam logic [16:0] BWCFG_SMALL = 17'h01402;
	localparam logic [16:0] EXIT_BIG    = 17'h09404;
	localparam logic [16:0] EXIT_SMALL  = 17'h01404;
	localparam logic [16:0] ID1_BIG     = 17'h09422;
	localparam logic [16:0] ID1_SMALL   = 17'h01422;
	localparam logic [16:0] BRCFG_BIG   = 17'h09424;
	localparam logic [16:0] BRCFG_SMALL = 17'h01424;
	localparam logic [16:0] DPORT_BIG   = 17'h09800;
	localparam logic [16:0] DPORT_SMALL = 17'h01800;
	// device control fields
	localparam int CTRL_SOFT_BIT = 2;
	localparam int CTRL_IDIS_BIT = 1;
	localparam logic [7:0] CTRL_WMASK = 8'h06;
	localparam logic [7:0] CTRL_RST   = 8'h00;
	// burst configuration fields
	localparam int CFG_HOLD_BIT = 13;
	localparam int CFG_LEN_LSB  = 11;
	localparam int CFG_LAT_LSB  = 8;
	localparam int CFG_WAIT_LSB = 4;
	localparam int CFG_EN_BIT   = 1;
	localparam logic [15:0] CFG_WMASK = 16'h3F32;
	localparam logic [15:0] CFG_RST   = 16'h0000;
	// identification value, arbitrary
	localparam logic [15:0] PART_ID_DEF = 16'h5A3C;
	// fixed part of the first word delay, in burst clocks
	localparam logic [2:0] LAT_BASE = 3'h2;
	localparam int FIFO_DEPTH = 32;
	typedef enum logic [2:0] {
		SEL_NONE, SEL_CTRL, SEL_ID0, SEL_ID1, SEL_BW, SEL_BR, SEL_EXIT
	} reg_sel_t;
	typedef enum logic [2:0] {
		B_IDLE, B_LAT, B_DATA, B_TRAIL, B_END
	} bst_t;
endpackage : hp_pkg

// ==== verif/host_model.sv ====
// host processor model: register cycles and burst cycles on the pins
`timescale 1ns/1ps
module host_model import hp_pkg::*; (
	input  wire logic        sys_clk,
	input  wire logic [15:0] reg_d_out,
	input  wire logic        reg_d_oe,
	input  wire logic [15:0] burst_d_out,
	input  wire logic        burst_d_oe,
	output logic             burst_clk,
	output logic             ce_n,
	output logic             oe_n,
	output logic             we_n,
	output logic [16:0]      addr,
	output logic [15:0]      d_bus
);
	logic        run;
	logic        h_oe;
	logic [15:0] h_d;
	logic [15:0] pat;
	logic [15:0] rq[$];

	// pins idle, link clock parked low
	initial begin
		{burst_clk, run, h_oe, ce_n, oe_n, we_n} = 6'h07;
		addr = '0;
		h_d = '0;
		pat = 16'h1234;
	end

	// link clock runs only while asked to, stops low
	always begin
		#62.5;
		if (run || burst_clk) burst_clk = ~burst_clk;
	end

	// released bus shows a changing pattern, never stale data
	always @(posedge sys_clk) pat <= pat + 16'h1357;
	assign d_bus = reg_d_oe ? reg_d_out : burst_d_oe ? burst_d_out :
		h_oe ? h_d : pat;

	// write cycle, even address, strobes low for 10 cycles
	task automatic reg_wr(input logic [16:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		#1 {ce_n, we_n, addr, h_d, h_oe} = {2'b00, a, d, 1'b1};
		repeat (10) @(posedge sys_clk);
		#1 {ce_n, we_n, h_oe} = 3'b110;
		repeat (10) @(posedge sys_clk);
	endtask : reg_wr

	// read cycle, data taken while strobes are still low
	task automatic reg_rd(input logic [16:0] a, output logic [15:0] d,
		output logic drv);
		@(posedge sys_clk);
		#1 {ce_n, oe_n, addr} = {2'b00, a};
		repeat (10) @(posedge sys_clk);
		d = d_bus;
		drv = reg_d_oe;
		#1 {ce_n, oe_n} = 2'b11;
		repeat (10) @(posedge sys_clk);
	endtask : reg_rd

	// free link clock edges, used while reset is held
	task automatic clocks(input int n);
		#1 run = 1;
		repeat (n) @(posedge burst_clk);
		#1 run = 0;
	endtask : clocks

	// stream burst on the data port; read words collect in rq
	task automatic burst(input logic wr, input int lat, h, n, wc,
		input logic [15:0] base);
		int e;
		int last;
		last = 1 + lat + n * h + (wr ? wc : (wc > 1 ? wc - 1 : 0));
		// clock runs ahead of the frame so settings and words settle
		run = 1;
		repeat (2) @(posedge burst_clk);
		#1 {ce_n, addr} = {1'b0, DPORT_BIG};
		if (wr) {we_n, h_oe, h_d} = {2'b01, base};
		else oe_n = 0;
		for (e = 1; e <= last; e++) begin
			@(posedge burst_clk);
			if (!wr && e >= 2 + lat && (e - 2 - lat) % h == 0 &&
				(e - 2 - lat) / h < n) rq.push_back(d_bus);
			if (wr && e >= 2 + lat && (e - 2 - lat) % h == h - 1)
				#1 h_d = base + 16'((e - 2 - lat) / h + 1);
		end
		#1 {ce_n, oe_n, we_n, h_oe} = 4'b1110;
		repeat (2) @(posedge burst_clk);
		#1 run = 0;
	endtask : burst
endmodule : host_model

// ==== verif/test_host_port.sv ====
// self-checking bench for the host port control block
`timescale 1ns/1ps
module test_host_port import hp_pkg::*; ;
	logic        sys_clk, soft_reset_bit, burst_clk, ce_n, oe_n, we_n;
	logic [16:0] addr;
	logic [15:0] d_bus, reg_d_out, burst_d_out, rd_data, wr_data;
	logic        reg_d_oe, burst_d_oe, dev_event, irq_n, soft_reset;
	logic        warm_boot, keep_burst, rd_valid, rd_ready, wr_valid;
	logic        rdy_s, seen_oe;
	int          err_count, n_tests;
	logic [15:0] wq[$];

	host_port u_host_port (.sys_clk, .soft_reset_bit, .burst_clk, .ce_n, .oe_n,
		.we_n, .addr, .d_in(d_bus), .reg_d_out, .reg_d_oe, .burst_d_out,
		.burst_d_oe, .dev_event, .irq_n, .soft_reset, .warm_boot,
		.keep_burst, .rd_data, .rd_valid, .rd_ready, .wr_data, .wr_valid);
	host_model u_host_model (.sys_clk, .reg_d_out, .reg_d_oe,
		.burst_d_out, .burst_d_oe, .burst_clk, .ce_n, .oe_n, .we_n,
		.addr, .d_bus);

	// system clock, 4 ns
	initial sys_clk = 0;
	always #2 sys_clk = ~sys_clk;

	// core side observers
	always @(negedge sys_clk) rdy_s <= rd_ready;
	always @(posedge sys_clk) if (wr_valid === 1'b1) wq.push_back(wr_data);
	always @(posedge burst_clk) if (burst_d_oe === 1'b1) seen_oe = 1;

	task automatic chk(input string nm, input logic [15:0] e, g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic chk1(input string nm, input logic e, g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %b seen %b", nm, e, g);
		end
	endtask : chk1

	task automatic rd(input logic [16:0] a, input logic [15:0] e,
		input logic de);
		logic [15:0] d;
		logic        v;
		u_host_model.reg_rd(a, d, v);
		chk1("driven", de, v);
		if (de) chk("rdata", e, d);
	endtask : rd

	function automatic logic [15:0] cfg(input int en, h, len, lat, wc);
		return {2'b0, 1'(h), 2'(len), 3'(lat), 2'b0, 2'(wc), 2'b0, 1'(en),
			1'b0};
	endfunction : cfg

	task automatic push(input logic [15:0] base, input int n);
		#1;
		for (int i = 0; i < n; i++) begin
			rd_data = base + 16'(i);
			rd_valid = 1;
			@(posedge sys_clk);
			while (rdy_s !== 1'b1) @(posedge sys_clk);
			#1;
		end
		rd_valid = 0;
	endtask : push

	task automatic t_regs;
		rd(CTRL_BIG, 16'h0000, 1);
		rd(BWCFG_BIG, 16'h0000, 1);
		rd(BRCFG_SMALL, 16'h0000, 1);
		u_host_model.reg_wr(ID0_BIG, 16'hFFFF);
		rd(ID0_BIG, PART_ID_DEF, 1);
		rd(ID0_SMALL, PART_ID_DEF, 1);
		rd(ID1_BIG, ~PART_ID_DEF, 1);
		rd(ID1_SMALL, ~PART_ID_DEF, 1);
		rd(EXIT_BIG, 16'h0000, 0);
		rd(ID0_BIG | 17'h1, 16'h0000, 0);
		rd(17'h09440, 16'h0000, 0);
		u_host_model.reg_wr(BWCFG_BIG, 16'hFFFF);
		rd(BWCFG_SMALL, 16'h3F32, 1);
		rd(BRCFG_BIG, 16'h0000, 1);
		u_host_model.reg_wr(BRCFG_SMALL, 16'hFFFF);
		rd(BRCFG_BIG, 16'h3F32, 1);
		u_host_model.reg_wr(BWCFG_BIG, 16'h0000);
	endtask : t_regs

	task automatic t_irq;
		#1 dev_event = 1;
		repeat (5) @(posedge sys_clk);
		chk1("irq_n", 0, irq_n);
		u_host_model.reg_wr(CTRL_SMALL, 16'h0002);
		chk1("irq_n", 1, irq_n);
		rd(CTRL_BIG, 16'h0002, 1);
		u_host_model.reg_wr(CTRL_BIG, 16'h0000);
		chk1("irq_n", 0, irq_n);
		#1 dev_event = 0;
		repeat (5) @(posedge sys_clk);
		chk1("irq_n", 1, irq_n);
	endtask : t_irq

	task automatic t_warm;
		u_host_model.reg_wr(BRCFG_BIG, 16'h0002);
		u_host_model.reg_wr(BWCFG_BIG, 16'h0002);
		for (int k = 1; k >= 0; k--) begin
			#1 {keep_burst, warm_boot} = {1'(k), 1'b1};
			@(posedge sys_clk);
			#1 warm_boot = 0;
			rd(BRCFG_BIG, 16'(2 * k), 1);
			rd(BWCFG_BIG, 16'(2 * k), 1);
		end
		u_host_model.reg_wr(EXIT_BIG, 16'h0000);
	endtask : t_warm

	task automatic t_rd_burst(input int len, lat, h, wc, input bit fill);
		logic [15:0] q[$];
		logic [15:0] base;
		int          k;
		base = 16'h1000 * 16'(len + 1);
		u_host_model.reg_wr(BRCFG_BIG, cfg(1, h, len, lat, wc));
		if (fill) begin
			#1 {rd_valid, rd_data} = {1'b1, base};
			k = 0;
			repeat (60) begin
				@(posedge sys_clk);
				if (rdy_s === 1'b1) k++;
				#1 rd_data = base + 16'(k);
			end
			chk1("fifo_refuses", 0, rdy_s);
			chk1("fifo_filled", 1, k >= FIFO_DEPTH);
			rd_valid = 0;
		end else push(base, 4 << len);
		repeat (20) @(posedge sys_clk);
		u_host_model.rq.delete();
		u_host_model.burst(0, lat, h + 1, 4 << len, wc, 16'h0);
		q = u_host_model.rq;
		chk("rd_count", 16'(4 << len), 16'(q.size()));
		foreach (q[i]) chk("rd_word", base + 16'(i), q[i]);
		chk1("burst_oe", 0, burst_d_oe);
	endtask : t_rd_burst

	task automatic t_rd_off;
		u_host_model.reg_wr(BRCFG_BIG, cfg(0, 0, 0, 0, 0));
		seen_oe = 0;
		u_host_model.burst(0, 0, 1, 4, 0, 16'h0);
		chk1("oe_when_off", 0, seen_oe);
	endtask : t_rd_off

	task automatic t_wr_burst;
		logic [15:0] q[$];
		u_host_model.reg_wr(BWCFG_SMALL, cfg(1, 1, 0, 2, 2));
		wq.delete();
		u_host_model.burst(1, 2, 2, 4, 2, 16'hA000);
		repeat (20) @(posedge sys_clk);
		q = wq;
		chk("wr_count", 16'h0004, 16'(q.size()));
		foreach (q[i]) chk("wr_word", 16'hA000 + 16'(i), q[i]);
		u_host_model.reg_wr(EXIT_SMALL, 16'h1234);
		wq.delete();
		u_host_model.burst(1, 2, 2, 4, 2, 16'hB000);
		repeat (20) @(posedge sys_clk);
		chk("wr_after_exit", 16'h0000, 16'(wq.size()));
	endtask : t_wr_burst

	task automatic t_soft;
		u_host_model.reg_wr(BRCFG_BIG, 16'h0002);
		u_host_model.reg_wr(CTRL_BIG, 16'h00FF);
		chk1("soft_reset", 1, soft_reset);
		rd(CTRL_BIG, 16'h0006, 1);
		rd(BRCFG_BIG, 16'h0000, 1);
		chk1("rd_ready", 1, rd_ready);
		u_host_model.reg_wr(BRCFG_BIG, 16'h0002);
		rd(BRCFG_BIG, 16'h0000, 1);
		u_host_model.reg_wr(CTRL_BIG, 16'h0000);
		chk1("soft_reset", 0, soft_reset);
		u_host_model.reg_wr(BRCFG_BIG, 16'h0002);
		rd(BRCFG_BIG, 16'h0002, 1);
	endtask : t_soft

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : report_and_stop

	// watchdog, far beyond the expected run of about 27 us
	initial begin
		#200000;
		err_count++;
		$display("BAD watchdog expected done seen hang");
		report_and_stop();
	end

	// reset with link clock edges, then the scenarios
	initial begin
		{soft_reset_bit, dev_event, warm_boot, keep_burst, rd_valid} = 5'h10;
		{rd_data, err_count, n_tests, seen_oe, rdy_s} = '0;
		fork
			u_host_model.clocks(4);
			repeat (3) @(posedge sys_clk);
		join
		@(posedge sys_clk);
		#1 soft_reset_bit = 0;
		repeat (6) @(posedge sys_clk);
		t_regs();
		t_irq();
		t_warm();
		t_rd_burst(0, 0, 0, 0, 0);
		t_rd_burst(1, 3, 1, 2, 0);
		t_rd_burst(2, 7, 0, 3, 0);
		t_rd_burst(3, 1, 1, 1, 1);
		t_rd_off();
		t_wr_burst();
		t_soft();
		report_and_stop();
	end
endmodule : test_host_port
